//--- sfl_params.svh
// constants of the serial flash command block
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH
`define SFL_CMD_ID        8'h90
`define SFL_CMD_LATCH_SET 8'h06
`define SFL_CMD_LATCH_CLR 8'h04
`define SFL_CMD_STAT_RD   8'h05
`define SFL_CMD_STAT_WR   8'h01
`define SFL_CMD_READ      8'h03
`define SFL_CMD_FAST      8'h0B
`define SFL_CMD_DUAL_OUT  8'h3B
`define SFL_CMD_DUAL_IO   8'hBB
`define SFL_CMD_QUAD_OUT  8'h6B
`define SFL_CMD_MODE_EXIT 8'hFF
`define SFL_ADDR_W        22
`define SFL_ADDR_BITS     5'h18
`define SFL_DUMMY_CLKS    5'h08
`define SFL_MODE_BITS     5'h08
`define SFL_BYTE_BITS     5'h08
`define SFL_MODE_CONT     4'hA
`define SFL_SR_BUSY       0
`define SFL_SR_LATCH      1
`define SFL_SR_BP_LO      2
`define SFL_SR_LOCK       7
`endif

//--- sfl_pkg.sv
// types of the serial flash command block
`default_nettype none
package sfl_pkg;
  typedef enum logic [2:0] {
    SFL_IDLE, SFL_CMD, SFL_ADDR, SFL_MODE,
    SFL_DUMMY, SFL_STAT_WR, SFL_OUT, SFL_IGNORE
  } sfl_state_e;
  typedef enum logic [1:0] {
    SFL_K_ARRAY, SFL_K_ID, SFL_K_STATUS
  } sfl_kind_e;
endpackage
`default_nettype wire

//--- sfl_device.sv
// serial flash command sequencer, device side
`timescale 1ns/1ns
`default_nettype none
`include "sfl_params.svh"
module sfl_device
  import sfl_pkg::*;
#(
  parameter int         ADDR_W        = `SFL_ADDR_W,
  parameter logic [7:0] MAKER_CODE_1  = 8'hA5, // arbitrary value
  parameter logic [7:0] MAKER_CODE_2  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_CODE_1 = 8'h3C  // arbitrary value
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // serial link
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              data_line_0_in,
  output logic                   data_line_0_out,
  output logic                   data_line_0_oe_n,
  input  wire logic              data_line_1_in,
  output logic                   data_line_1_out,
  output logic                   data_line_1_oe_n,
  output logic                   data_line_2_out,
  output logic                   data_line_2_oe_n,
  output logic                   data_line_3_out,
  output logic                   data_line_3_oe_n,
  // array read port
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [7:0]        mem_data,
  // internal write engine
  input  wire logic              write_in_progress_flag,
  input  wire logic              op_done,
  // status bits
  output logic                   write_enable_latch,
  output logic                   block_protect_3,
  output logic                   block_protect_2,
  output logic                   block_protect_1,
  output logic                   block_protect_0,
  output logic                   status_lock_bit,
  output logic                   continuous_mode
);

  // ----------------------------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------------------------
  logic [2:0] sck_sync_q;
  logic [2:0] csn_sync_q;
  logic [1:0] d0_sync_q;
  logic [1:0] d1_sync_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_sync_q <= 3'h0;
      csn_sync_q <= 3'h7;
      d0_sync_q  <= 2'h0;
      d1_sync_q  <= 2'h0;
    end
    else
    begin
      sck_sync_q <= {sck_sync_q[1:0], sck};
      csn_sync_q <= {csn_sync_q[1:0], cs_n};
      d0_sync_q  <= {d0_sync_q[0], data_line_0_in};
      d1_sync_q  <= {d1_sync_q[0], data_line_1_in};
    end
  end

  wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
  wire sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
  wire selected = ~csn_sync_q[1];
  wire sel_start = selected & csn_sync_q[2];
  wire in0 = d0_sync_q[1];
  wire in1 = d1_sync_q[1];
  wire busy = write_in_progress_flag;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  sfl_state_e      st_q;
  sfl_kind_e       kind_q;
  logic [7:0]      cmd_q;
  logic [23:0]     a_q;
  logic [ADDR_W-1:0] addr_q;
  logic [4:0]      cnt_q;
  logic [2:0]      in_w_q;
  logic [2:0]      out_w_q;
  logic            fast_q;
  logic            dio_q;
  logic            cont_q;
  logic            a0_q;
  logic [1:0]      idx_q;
  logic [2:0]      ocnt_q;
  logic [7:0]      sh_q;
  logic [3:0]      io_q;
  logic            drive_q;
  logic            latch_q;
  logic [3:0]      bp_q;
  logic            lock_q;

  // ----------------------------------------------------------
  // decoding and selection
  // ----------------------------------------------------------
  wire [7:0]  cmd_byte = {cmd_q[6:0], in0};
  wire [4:0]  cnt_nx   = cnt_q + {2'h0, in_w_q};
  wire [4:0]  cnt_one  = cnt_q + 5'h01;
  wire [23:0] a_nx     = dio_q ? {a_q[21:0], in1, in0}
                               : {a_q[22:0], in0};
  wire        id_first = (idx_q == 2'h0) ^ a0_q;
  wire [7:0]  id_byte  = (idx_q == 2'h2) ? MAKER_CODE_2
                       : id_first ? MAKER_CODE_1 : DEVICE_CODE_1;
  wire [7:0]  st_byte  = {lock_q, 1'b0, bp_q, latch_q, busy};
  wire [7:0]  src_byte = (kind_q == SFL_K_ID) ? id_byte
                       : (kind_q == SFL_K_STATUS) ? st_byte
                       : mem_data;
  wire [7:0]  out_byte = (ocnt_q == 3'h0) ? src_byte : sh_q;
  wire [3:0]  chunk    = (out_w_q == 3'h4) ? out_byte[7:4]
                       : (out_w_q == 3'h2) ?
                         {2'h0, out_byte[7], out_byte[6]}
                       : {2'h0, out_byte[7], 1'b0};
  wire [3:0]  line_use = (out_w_q == 3'h4) ? 4'hF
                       : (out_w_q == 3'h2) ? 4'h3 : 4'h2;
  wire [3:0]  oe_n     = ~(line_use & {4{drive_q}});
  wire        byte_end = (ocnt_q == 3'h0);

  // ----------------------------------------------------------
  // command engine
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q    <= SFL_IDLE;
      kind_q  <= SFL_K_ARRAY;
      cmd_q   <= 8'h00;
      a_q     <= 24'h000000;
      addr_q  <= '0;
      cnt_q   <= 5'h00;
      in_w_q  <= 3'h1;
      out_w_q <= 3'h1;
      fast_q  <= 1'b0;
      dio_q   <= 1'b0;
      cont_q  <= 1'b0;
      a0_q    <= 1'b0;
      idx_q   <= 2'h0;
      ocnt_q  <= 3'h0;
      sh_q    <= 8'h00;
      io_q    <= 4'h0;
      drive_q <= 1'b0;
      latch_q <= 1'b0;
      bp_q    <= 4'h0;
      lock_q  <= 1'b0;
    end
    else
    begin
      if (op_done)
        latch_q <= 1'b0;
      if (!selected)
      begin
        st_q    <= SFL_IDLE;
        drive_q <= 1'b0;
        cnt_q   <= 5'h00;
      end
      else if (sel_start)
      begin
        cnt_q   <= 5'h00;
        ocnt_q  <= 3'h0;
        idx_q   <= 2'h0;
        kind_q  <= SFL_K_ARRAY;
        fast_q  <= 1'b0;
        if (cont_q && !busy)
        begin
          st_q    <= SFL_ADDR;
          dio_q   <= 1'b1;
          in_w_q  <= 3'h2;
          out_w_q <= 3'h2;
        end
        else
        begin
          st_q    <= busy && cont_q ? SFL_IGNORE : SFL_CMD;
          dio_q   <= 1'b0;
          in_w_q  <= 3'h1;
          out_w_q <= 3'h1;
        end
      end
      else if (sck_rise)
      begin
        case (st_q)
          SFL_CMD:
          begin
            cmd_q <= cmd_byte;
            cnt_q <= cnt_one;
            if (cnt_q == 5'h07)
            begin
              cnt_q <= 5'h00;
              st_q  <= SFL_IGNORE;
              if (busy && cmd_byte != `SFL_CMD_STAT_RD)
                st_q <= SFL_IGNORE;
              else if (cmd_byte == `SFL_CMD_LATCH_SET)
                latch_q <= 1'b1;
              else if (cmd_byte == `SFL_CMD_LATCH_CLR)
                latch_q <= 1'b0;
              else if (cmd_byte == `SFL_CMD_STAT_RD)
              begin
                kind_q <= SFL_K_STATUS;
                st_q   <= SFL_OUT;
              end
              else if (cmd_byte == `SFL_CMD_STAT_WR)
                st_q <= latch_q ? SFL_STAT_WR : SFL_IGNORE;
              else if (cmd_byte == `SFL_CMD_ID)
              begin
                kind_q <= SFL_K_ID;
                st_q   <= SFL_ADDR;
              end
              else if (cmd_byte == `SFL_CMD_READ)
                st_q <= SFL_ADDR;
              else if (cmd_byte == `SFL_CMD_FAST)
              begin
                fast_q <= 1'b1;
                st_q   <= SFL_ADDR;
              end
              else if (cmd_byte == `SFL_CMD_DUAL_OUT)
              begin
                fast_q  <= 1'b1;
                out_w_q <= 3'h2;
                st_q    <= SFL_ADDR;
              end
              else if (cmd_byte == `SFL_CMD_QUAD_OUT)
              begin
                fast_q  <= 1'b1;
                out_w_q <= 3'h4;
                st_q    <= SFL_ADDR;
              end
              else if (cmd_byte == `SFL_CMD_DUAL_IO)
              begin
                dio_q   <= 1'b1;
                in_w_q  <= 3'h2;
                out_w_q <= 3'h2;
                st_q    <= SFL_ADDR;
              end
              else if (cmd_byte == `SFL_CMD_MODE_EXIT)
                cont_q <= 1'b0;
            end
          end
          SFL_ADDR:
          begin
            a_q   <= a_nx;
            cnt_q <= cnt_nx;
            if (cnt_nx == `SFL_ADDR_BITS)
            begin
              cnt_q  <= 5'h00;
              addr_q <= a_nx[ADDR_W-1:0];
              a0_q   <= a_nx[0];
              if (kind_q == SFL_K_ID)
                st_q <= SFL_OUT;
              else if (dio_q)
                st_q <= SFL_MODE;
              else if (fast_q)
                st_q <= SFL_DUMMY;
              else
                st_q <= SFL_OUT;
            end
          end
          SFL_MODE:
          begin
            a_q   <= a_nx;
            cnt_q <= cnt_nx;
            if (cnt_nx == `SFL_MODE_BITS)
            begin
              cont_q <= (a_nx[7:4] == `SFL_MODE_CONT);
              st_q   <= SFL_OUT;
            end
          end
          SFL_DUMMY:
          begin
            cnt_q <= cnt_one;
            if (cnt_one == `SFL_DUMMY_CLKS)
              st_q <= SFL_OUT;
          end
          SFL_STAT_WR:
          begin
            cmd_q <= cmd_byte;
            cnt_q <= cnt_one;
            if (cnt_one == `SFL_BYTE_BITS)
            begin
              bp_q   <= cmd_byte[`SFL_SR_BP_LO+3:`SFL_SR_BP_LO];
              lock_q <= cmd_byte[`SFL_SR_LOCK];
              latch_q <= 1'b0;
              st_q   <= SFL_IGNORE;
            end
          end
          default:
          begin
          end
        endcase
      end
      else if (sck_fall && st_q == SFL_OUT)
      begin
        drive_q <= 1'b1;
        io_q    <= chunk;
        sh_q    <= out_byte << out_w_q;
        ocnt_q  <= ocnt_q + out_w_q;
        if (byte_end && kind_q == SFL_K_ARRAY)
          addr_q <= addr_q + 1'b1;
        if (byte_end && kind_q == SFL_K_ID)
          idx_q <= (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign data_line_0_out  = io_q[0];
  assign data_line_1_out  = io_q[1];
  assign data_line_2_out  = io_q[2];
  assign data_line_3_out  = io_q[3];
  assign data_line_0_oe_n = oe_n[0];
  assign data_line_1_oe_n = oe_n[1];
  assign data_line_2_oe_n = oe_n[2];
  assign data_line_3_oe_n = oe_n[3];
  assign mem_addr           = addr_q;
  assign write_enable_latch = latch_q;
  assign block_protect_3    = bp_q[3];
  assign block_protect_2    = bp_q[2];
  assign block_protect_1    = bp_q[1];
  assign block_protect_0    = bp_q[0];
  assign status_lock_bit    = lock_q;
  assign continuous_mode    = cont_q;

endmodule // sfl_device
`default_nettype wire

//--- sfl_device_asserts.sv
// assertion checker for the serial flash command block
`timescale 1ns/1ns
`default_nettype none
module sfl_device_asserts
  import sfl_pkg::*;
#(
  parameter int ADDR_W = 22
)(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rstn,
  // serial link
  input wire logic              sck,
  input wire logic              cs_n,
  input wire logic              data_line_0_oe_n,
  input wire logic              data_line_1_out,
  input wire logic              data_line_1_oe_n,
  input wire logic              data_line_2_oe_n,
  input wire logic              data_line_3_oe_n,
  // array and write engine
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              write_in_progress_flag,
  input wire logic              op_done,
  // status bits
  input wire logic              write_enable_latch,
  input wire logic              block_protect_3,
  input wire logic              block_protect_2,
  input wire logic              block_protect_1,
  input wire logic              block_protect_0,
  input wire logic              status_lock_bit,
  input wire logic              continuous_mode
);
  logic [2:0] cs_hi_q;
  logic       busy_q;
  wire logic  desel = cs_hi_q > 3'h5;
  wire logic [4:0] prot = {status_lock_bit, block_protect_3,
    block_protect_2, block_protect_1, block_protect_0};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // ------
  // select-high cycle count, busy seen while deselected
  // ------
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      cs_hi_q <= 3'h0;
    else if (!cs_n)
      cs_hi_q <= 3'h0;
    else if (cs_hi_q != 3'h7)
      cs_hi_q <= cs_hi_q + 3'h1;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      busy_q <= 1'b0;
    else
      busy_q <= write_in_progress_flag && (busy_q || desel);
  idle_release_a: assert property (
    desel |-> data_line_0_oe_n && data_line_1_oe_n && data_line_2_oe_n
      && data_line_3_oe_n) else $error("line driven while deselected");
  busy_quiet_a: assert property (
    busy_q |-> data_line_0_oe_n && data_line_2_oe_n && data_line_3_oe_n)
    else $error("read served while busy");
  latch_done_a: assert property (
    desel && op_done |=> !write_enable_latch) else $error("latch kept");
  latch_fall_a: assert property (
    $fell(write_enable_latch) |-> $past(op_done) || !$past(cs_n, 3))
    else $error("latch cleared without cause");
  latch_rise_a: assert property (
    $rose(write_enable_latch) |-> !$past(cs_n, 3)) else $error("latch set");
  prot_store_a: assert property (
    !$stable(prot) |-> ($past(write_enable_latch) ||
      $past(write_enable_latch, 2)) && !$past(cs_n, 3))
    else $error("protect bits changed");
  addr_step_a: assert property (
    $changed(mem_addr) && !data_line_1_oe_n && !$past(data_line_1_oe_n)
    && !$past(data_line_1_oe_n, 2) |-> mem_addr == $past(mem_addr) + 1'b1)
    else $error("address step");
  data_hold_a: assert property (
    sck && $past(sck) && !data_line_1_oe_n && !$past(data_line_1_oe_n)
    |-> $stable(data_line_1_out)) else $error("output moved in high phase");
  quad_lines_a: assert property (
    !data_line_3_oe_n |-> !data_line_0_oe_n && !data_line_1_oe_n
      && !data_line_2_oe_n) else $error("quad lines split");
  cover property ($rose(continuous_mode));
  cover property (!data_line_3_oe_n);
  cover property (busy_q && !data_line_1_oe_n);
endmodule // sfl_device_asserts
`default_nettype wire

//--- sfl_host.sv
// host bus master model for the serial flash link
`timescale 1ns/1ns
`default_nettype none
module sfl_host
  import sfl_pkg::*;
(
  // clock
  input  wire logic mclk,
  // serial link
  output logic      sck,
  output logic      cs_n,
  output logic      data_line_0_in,
  output logic      data_line_1_in,
  input  wire logic data_line_0_out,
  input  wire logic data_line_0_oe_n,
  input  wire logic data_line_1_out,
  input  wire logic data_line_1_oe_n,
  input  wire logic data_line_2_out,
  input  wire logic data_line_2_oe_n,
  input  wire logic data_line_3_out,
  input  wire logic data_line_3_oe_n
);
  logic hd;
  logic h0;
  logic h1;
  // lines 0 and 1 released by the device show the host bit when hd is set, else its inverse; released lines 2 and 3 float
  wire logic l0 = !data_line_0_oe_n ? data_line_0_out : hd ? h0 : !h0;
  wire logic l1 = !data_line_1_oe_n ? data_line_1_out : hd ? h1 : !h1;
  wire logic l2 = data_line_2_oe_n ? 1'bz : data_line_2_out;
  wire logic l3 = data_line_3_oe_n ? 1'bz : data_line_3_out;
  assign data_line_0_in = l0;
  assign data_line_1_in = l1;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    hd = 1'b0;
    h0 = 1'b0;
    h1 = 1'b0;
  end
  // ------
  // frame and byte tasks
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic start();
    tick(1);
    cs_n = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    cs_n = 1'b1;
    hd = 1'b0;
    tick(6);
  endtask
  // one byte at w bits per clock; drv low leaves the lines to the device
  task automatic xb(input logic [7:0] tx, input int w, input logic drv,
                    output logic [7:0] rx);
    logic [3:0] ch;
    rx = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      hd = drv;
      h1 = tx[7-i];
      h0 = tx[7-i-((w == 2) ? 1 : 0)];
      tick(4);
      sck = 1'b1;
      tick(4);
      ch = (w == 4) ? {l3, l2, l1, l0} : (w == 2) ? {2'b00, l1, l0}
        : {3'b000, l1};
      rx = (rx << w) | {4'h0, ch};
      sck = 1'b0;
    end
  endtask
endmodule // sfl_host
`default_nettype wire

//--- tb_sfl_device.sv
// self-checking bench for the serial flash command block
`timescale 1ns/1ns
`default_nettype none
module tb_sfl_device
  import sfl_pkg::*;
;
  localparam logic [7:0] M1 = 8'hC3; // arbitrary value
  localparam logic [7:0] D1 = 8'h81; // arbitrary value
  localparam logic [7:0] M2 = 8'h6E; // arbitrary value
  logic mclk, rstn, write_in_progress_flag, op_done;
  wire logic sck, cs_n, data_line_0_in, data_line_1_in;
  wire logic data_line_0_out, data_line_0_oe_n, data_line_1_out;
  wire logic data_line_1_oe_n, data_line_2_out, data_line_2_oe_n;
  wire logic data_line_3_out, data_line_3_oe_n, write_enable_latch;
  wire logic block_protect_3, block_protect_2, block_protect_1;
  wire logic block_protect_0, status_lock_bit, continuous_mode;
  wire logic [21:0] mem_addr;
  wire logic [7:0]  mem_data;
  logic [7:0] rx;
  logic [7:0] ops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
  int         wid [4] = '{1, 1, 2, 4};
  int n_errors = 0;
  int comparisons = 0;
  function automatic logic [7:0] fm(input logic [21:0] a);
    return a[7:0] ^ {2'b00, a[21:16]};
  endfunction
  assign mem_data = fm(mem_addr);
  sfl_device #(.MAKER_CODE_1(M1), .MAKER_CODE_2(M2), .DEVICE_CODE_1(D1))
    i_dut (.*);
  sfl_host i_host (.*);
  always #25 mclk = ~mclk;
  // ------
  // access tasks
  // ------
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic cmd(input logic [7:0] op, d, input int n);
    i_host.start();
    i_host.xb(op, 1, 1'b1, rx);
    if (n > 1)
      i_host.xb(d, 1, 1'b1, rx);
    i_host.stop();
  endtask
  task automatic status_read_cmd(input logic [7:0] exp);
    i_host.start();
    i_host.xb(8'h05, 1, 1'b1, rx);
    for (int k = 0; k < 2; k++)
    begin
      i_host.xb(8'h00, 1, 1'b0, rx);
      chk("status", exp, rx);
    end
    i_host.stop();
  endtask
  // op 00 marks a continuous-mode frame without opcode
  task automatic rd(input logic [7:0] op, input logic [23:0] a,
                    input int aw, nd, w);
    i_host.start();
    if (op != 8'h00)
      i_host.xb(op, 1, 1'b1, rx);
    for (int k = 2; k >= 0; k--)
      i_host.xb(a[8*k +: 8], aw, 1'b1, rx);
    for (int k = 0; k < nd; k++)
      i_host.xb(8'hA0, aw, 1'b1, rx);
    for (int k = 0; k < 2; k++)
    begin
      i_host.xb(8'h00, w, 1'b0, rx);
      chk("array", fm(a[21:0] + 22'(k)), rx);
    end
    i_host.stop();
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_errors++;
    test_done();
  end
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    write_in_progress_flag = 1'b0;
    op_done = 1'b0;
    repeat (12) @(posedge mclk);
    #5 rstn = 1'b1;
    chk("latch", 8'h00, {7'h00, write_enable_latch});
    i_host.tick(3);
    status_read_cmd(8'h00);
    for (int a = 0; a < 2; a++)
    begin
      i_host.start();
      i_host.xb(8'h90, 1, 1'b1, rx);
      i_host.xb(8'h00, 1, 1'b1, rx);
      i_host.xb(8'h00, 1, 1'b1, rx);
      i_host.xb({7'h55, a[0]}, 1, 1'b1, rx);
      for (int k = 0; k < 4; k++)
      begin
        i_host.xb(8'h00, 1, 1'b0, rx);
        chk("id", (k % 3 == 2) ? M2 : ((k % 3 == 0) ^ a[0]) ? M1 : D1,
            rx);
      end
      i_host.stop();
    end
    cmd(8'h06, 8'h00, 1);
    status_read_cmd(8'h02);
    cmd(8'h04, 8'h00, 1);
    status_read_cmd(8'h00);
    cmd(8'h01, 8'h9C, 2);
    status_read_cmd(8'h00);
    cmd(8'h06, 8'h00, 1);
    cmd(8'h01, 8'h9C, 2);
    status_read_cmd(8'h9C);
    cmd(8'h06, 8'h00, 1);
    op_done = 1'b1;
    i_host.tick(1);
    op_done = 1'b0;
    chk("latch", 8'h00, {7'h00, write_enable_latch});
    for (int k = 0; k < 4; k++)
      rd(ops[k], 24'hFFFFFF - 24'(k), 1, k > 0, wid[k]);
    rd(8'hBB, 24'h401234, 2, 1, 2);
    chk("mode", 8'h01, {7'h00, continuous_mode});
    rd(8'h00, 24'hC3FFFF, 2, 1, 2);
    cmd(8'hFF, 8'hFF, 2);
    chk("mode", 8'h00, {7'h00, continuous_mode});
    write_in_progress_flag = 1'b1;
    status_read_cmd(8'h9D);
    cmd(8'h06, 8'h00, 1);
    i_host.start();
    i_host.xb(8'h3B, 1, 1'b1, rx);
    for (int k = 0; k < 4; k++)
      i_host.xb(8'h12, 1, 1'b1, rx);
    i_host.xb(8'h00, 2, 1'b0, rx);
    chk("release", 8'h03, {6'h00, data_line_1_oe_n, data_line_0_oe_n});
    i_host.stop();
    write_in_progress_flag = 1'b0;
    status_read_cmd(8'h9C);
    test_done();
  end
endmodule // tb_sfl_device
bind sfl_device sfl_device_asserts #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire
